/* File: hw/rcraoc_core.sv */
// Register file, status word and operand handling of the core, with its memory sequencer.
// Assumes one decoded operation per cycle on the op port and a memory whose read data
// stand, right-justified, in the cycle after mem_req is seen high.
`include "rcraoc_regs.svh"
`default_nettype none
module rcraoc_core #(
  parameter int unsigned MUL16_CYCLES = `RC_MUL16_CYC,
  parameter int unsigned MAC16_CYCLES = `RC_MAC16_CYC,
  parameter int unsigned MUL32_CYCLES = `RC_MUL32_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic [7:0]            sw_addr,
  input  wire logic [31:0]           sw_wdata,
  input  wire logic                  sw_wr,
  input  wire logic                  sw_rd,
  output logic      [31:0]           sw_rdata,
  input  wire logic                  op_valid,
  input  wire rcraoc_pkg::rcraoc_op_t op_code,
  input  wire logic [3:0]            op_rn,
  input  wire logic [3:0]            op_rm,
  input  wire logic [7:0]            op_imm,
  input  wire rcraoc_pkg::rcraoc_size_t op_size,
  input  wire logic                  op_idx,
  input  wire logic [11:0]           op_disp,
  output logic                       op_ready,
  output logic      [31:0]           fetch_addr,
  output logic                       mem_req,
  output logic                       mem_we,
  output rcraoc_pkg::rcraoc_size_t   mem_size,
  output logic      [31:0]           mem_addr,
  output logic      [31:0]           mem_wdata,
  input  wire logic [31:0]           mem_rdata,
  output logic                       addr_err
);
  if (MUL16_CYCLES < 2 || MAC16_CYCLES < 2 || MUL32_CYCLES < 2 ||
      MUL16_CYCLES > 7 || MAC16_CYCLES > 7 || MUL32_CYCLES > 7) begin : g_chk
    $error("Multiply cycle counts must lie between 2 and 7.");
  end

  logic [31:0] gpr_r [0:15];
  logic [31:0] sr_r, pbp_r, vtb_r, mac_high_half_r, mac_low_half_r, rlink_r, ip_r, tgt_r;
  logic        pend_r, fault_r, op_ready_r, addr_err_r;
  logic        mem_req_r, mem_we_r;
  logic [31:0] mem_addr_r, mem_wdata_r, sw_rdata_r;
  rcraoc_pkg::rcraoc_size_t msz_r, ldsz_r;
  rcraoc_pkg::rcraoc_st_t   st_r, st_nxt;
  rcraoc_pkg::rcraoc_seq_t  seq_r, seq_nxt;
  logic [3:0]  dst_r;
  logic [7:0]  imm_r;
  logic [2:0]  mcnt_r;
  logic [63:0] mres_r, mres_nxt;

  // Two read ports, a result port and a stack port.
  wire [31:0] rn_val = gpr_r[op_rn];
  wire [31:0] rm_val = gpr_r[op_rm];
  wire [31:0] r0_val = gpr_r[0];
  wire [31:0] sp_val = gpr_r[`RC_SP_IDX];
  wire [31:0] sp_m4  = sp_val - `RC_STACK_STEP;
  wire [31:0] sp_p4  = sp_val + `RC_STACK_STEP;
  wire        take   = op_valid && op_ready_r;
  wire        t_now  = sr_r[`RC_SR_T];

  wire [31:0] imm_sx = {{24{op_imm[7]}}, op_imm};
  wire [31:0] imm_zx = {24'h000000, op_imm};

  wire [31:0] ld_ea  = rm_val + (op_idx ? r0_val : 32'h00000000);
  // Literal table offset scaled by four for words, by two for halfwords and bytes.
  wire [31:0] lit_off = (op_size == rcraoc_pkg::SZ_L) ? {22'h000000, op_imm, 2'b00}
                                                      : {23'h000000, op_imm, 1'b0};
  wire [31:0] lit_base = (op_size == rcraoc_pkg::SZ_L) ? {ip_r[31:2], 2'b00} : ip_r;
  wire [31:0] lit_ea  = lit_base + `RC_BR_BIAS + lit_off;
  // Peripheral base plus index for memory bit logic.
  wire [31:0] pbp_ea  = pbp_r + r0_val;
  wire [31:0] br_tgt  = ip_r + `RC_BR_BIAS + {{19{op_disp[11]}}, op_disp, 1'b0};
  wire [31:0] vec_ea  = vtb_r + {22'h000000, imm_r, 2'b00};

  wire is_ld   = (op_code == rcraoc_pkg::OP_LOAD);
  wire is_st   = (op_code == rcraoc_pkg::OP_STORE);
  wire is_lit  = (op_code == rcraoc_pkg::OP_LOAD_LIT);
  wire is_mem  = is_ld || is_st || is_lit;
  wire [31:0] mem_ea = is_lit ? lit_ea : ld_ea;
  // Halfword on odd or word off a four-byte boundary.
  wire mis_ea  = (op_size == rcraoc_pkg::SZ_W && mem_ea[0]) ||
                 (op_size == rcraoc_pkg::SZ_L && mem_ea[1:0] != 2'b00);
  wire mis_sp  = (sp_val[1:0] != 2'b00);

  wire [31:0] ld_val = (ldsz_r == rcraoc_pkg::SZ_B) ? {{24{mem_rdata[7]}}, mem_rdata[7:0]} :
                       (ldsz_r == rcraoc_pkg::SZ_W) ? {{16{mem_rdata[15]}}, mem_rdata[15:0]} :
                       mem_rdata;

  // Signed products for the multiply halves.
  wire signed [31:0] p16 = $signed(rn_val[15:0]) * $signed(rm_val[15:0]);
  wire signed [63:0] p32 = $signed(rn_val) * $signed(rm_val);
  wire [63:0] acc = {mac_high_half_r, mac_low_half_r};

  wire [4:0] sw_idx = sw_addr[6:2];
  wire       sw_ok  = (sw_addr[1:0] == 2'b00) && !sw_addr[7];
  wire       sw_wgp = sw_wr && sw_ok && !sw_idx[4];
  wire       sw_wx  = sw_wr && sw_ok;
  wire [31:0] sw_sel =
    !sw_ok                       ? 32'h00000000 :
    !sw_idx[4]                   ? gpr_r[sw_idx[3:0]] :
    (sw_idx == `RC_IDX_SR)       ? sr_r :
    (sw_idx == `RC_IDX_PBP)      ? pbp_r :
    (sw_idx == `RC_IDX_VTB)      ? vtb_r :
    (sw_idx == `RC_IDX_MAC_HIGH_HALF)     ? mac_high_half_r :
    (sw_idx == `RC_IDX_MAC_LOW_HALF)     ? mac_low_half_r :
    (sw_idx == `RC_IDX_RLINK)    ? rlink_r :
    (sw_idx == `RC_IDX_IP)       ? ip_r :
    (sw_idx == `RC_IDX_FAULT)    ? {31'h00000000, fault_r} : 32'h00000000;

  logic [31:0] alu_res, gval_a, gval_b, ip_val, sr_val, maddr_nxt, mwd_nxt;
  logic [3:0]  alu_dst, gidx_a;
  logic        alu_we, t_we, t_val, gwe_a, gwe_b, ip_we, sr_we;
  logic        mreq_nxt, mwe_nxt, aerr_nxt, pend_nxt, rl_we;
  logic [2:0]  mcnt_nxt;
  rcraoc_pkg::rcraoc_size_t msz_nxt;

  always_comb begin
    alu_res = rn_val;
    alu_dst = op_rn;
    alu_we  = 1'b0;
    t_we    = 1'b0;
    t_val   = t_now;
    case (op_code)
      rcraoc_pkg::OP_MOV_IMM: begin alu_res = imm_sx; alu_we = 1'b1; end
      rcraoc_pkg::OP_ADD_IMM: begin alu_res = rn_val + imm_sx; alu_we = 1'b1; end
      rcraoc_pkg::OP_MOV_REG: begin alu_res = rm_val; alu_we = 1'b1; end
      rcraoc_pkg::OP_ADD_REG: begin alu_res = rn_val + rm_val; alu_we = 1'b1; end
      rcraoc_pkg::OP_CMPEQ_IMM: begin t_we = 1'b1; t_val = (rn_val == imm_sx); end
      rcraoc_pkg::OP_CMPEQ_REG: begin t_we = 1'b1; t_val = (rn_val == rm_val); end
      rcraoc_pkg::OP_TST_IMM: begin t_we = 1'b1; t_val = ((r0_val & imm_zx) == 32'h0); end
      rcraoc_pkg::OP_AND_IMM: begin alu_res = r0_val & imm_zx; alu_dst = 4'h0; alu_we = 1'b1; end
      rcraoc_pkg::OP_OR_IMM: begin alu_res = r0_val | imm_zx; alu_dst = 4'h0; alu_we = 1'b1; end
      rcraoc_pkg::OP_XOR_IMM: begin alu_res = r0_val ^ imm_zx; alu_dst = 4'h0; alu_we = 1'b1; end
      default: begin alu_res = rn_val; end
    endcase
  end

  always_comb begin
    mres_nxt = acc;
    mcnt_nxt = mcnt_r - 3'h1;
    case (op_code)
      rcraoc_pkg::OP_MUL16: begin
        mres_nxt = {mac_high_half_r, p16};
        mcnt_nxt = 3'(MUL16_CYCLES - 1);
      end
      rcraoc_pkg::OP_MAC16: begin
        mres_nxt = acc + {{32{p16[31]}}, p16};
        mcnt_nxt = 3'(MAC16_CYCLES - 1);
      end
      rcraoc_pkg::OP_MUL32: begin
        mres_nxt = p32;
        mcnt_nxt = 3'(MUL32_CYCLES - 1);
      end
      rcraoc_pkg::OP_MAC32: begin
        mres_nxt = acc + p32;
        mcnt_nxt = 3'(MUL32_CYCLES - 1);
      end
      default: begin mres_nxt = acc; end
    endcase
  end

  // The sequencer owns the memory port; a stalled op port is its only back-pressure.
  always_comb begin
    st_nxt = st_r;
    seq_nxt = seq_r;
    mreq_nxt = 1'b0;
    mwe_nxt = 1'b0;
    msz_nxt = rcraoc_pkg::SZ_L;
    maddr_nxt = mem_addr_r;
    mwd_nxt = mem_wdata_r;
    aerr_nxt = 1'b0;
    gwe_a = 1'b0;
    gidx_a = alu_dst;
    gval_a = alu_res;
    gwe_b = 1'b0;
    gval_b = sp_val;
    ip_we = 1'b0;
    ip_val = ip_r + `RC_INSN_STEP;
    sr_we = 1'b0;
    sr_val = sr_r;
    pend_nxt = pend_r;
    rl_we = 1'b0;
    unique case (st_r)
      // Program pointer first, then stack, from the vector table.
      rcraoc_pkg::S_BOOT: begin
        mreq_nxt = 1'b1;
        maddr_nxt = vtb_r + `RC_VEC_PC_OFS;
        seq_nxt = rcraoc_pkg::Q_BOOT_PC;
        st_nxt = rcraoc_pkg::S_REQ;
      end
      rcraoc_pkg::S_REQ: st_nxt = rcraoc_pkg::S_DAT;
      rcraoc_pkg::S_MUL: if (mcnt_r == 3'h1) st_nxt = rcraoc_pkg::S_RUN;
      rcraoc_pkg::S_DAT: begin
        st_nxt = rcraoc_pkg::S_RUN;
        case (seq_r)
          rcraoc_pkg::Q_BOOT_PC: begin
            ip_we = 1'b1;
            ip_val = mem_rdata;
            mreq_nxt = 1'b1;
            maddr_nxt = vtb_r + `RC_VEC_SP_OFS;
            seq_nxt = rcraoc_pkg::Q_BOOT_SP;
            st_nxt = rcraoc_pkg::S_REQ;
          end
          rcraoc_pkg::Q_BOOT_SP: begin gwe_b = 1'b1; gval_b = mem_rdata; end
          rcraoc_pkg::Q_LOAD: begin gwe_a = 1'b1; gidx_a = dst_r; gval_a = ld_val; end
          // Bit logic writes the byte back in place.
          rcraoc_pkg::Q_RMW_RD: begin
            mreq_nxt = 1'b1;
            mwe_nxt = 1'b1;
            msz_nxt = rcraoc_pkg::SZ_B;
            mwd_nxt = {24'h000000, mem_rdata[7:0] & imm_r};
            seq_nxt = rcraoc_pkg::Q_RMW_WR;
            st_nxt = rcraoc_pkg::S_REQ;
          end
          // Second push holds the return pointer.
          rcraoc_pkg::Q_EXC_SR: begin
            gwe_b = 1'b1;
            gval_b = sp_m4;
            mreq_nxt = 1'b1;
            mwe_nxt = 1'b1;
            maddr_nxt = sp_m4;
            mwd_nxt = ip_r;
            seq_nxt = rcraoc_pkg::Q_EXC_PC;
            st_nxt = rcraoc_pkg::S_REQ;
          end
          // Vector fetched relative to the table base.
          rcraoc_pkg::Q_EXC_PC: begin
            mreq_nxt = 1'b1;
            maddr_nxt = vec_ea;
            seq_nxt = rcraoc_pkg::Q_EXC_VEC;
            st_nxt = rcraoc_pkg::S_REQ;
          end
          rcraoc_pkg::Q_EXC_VEC: begin ip_we = 1'b1; ip_val = mem_rdata; end
          rcraoc_pkg::Q_RTE_PC: begin
            ip_we = 1'b1;
            ip_val = mem_rdata;
            gwe_b = 1'b1;
            gval_b = sp_p4;
            mreq_nxt = 1'b1;
            maddr_nxt = sp_p4;
            seq_nxt = rcraoc_pkg::Q_RTE_SR;
            st_nxt = rcraoc_pkg::S_REQ;
          end
          rcraoc_pkg::Q_RTE_SR: begin
            sr_we = 1'b1;
            sr_val = mem_rdata & `RC_SR_MASK;
            gwe_b = 1'b1;
            gval_b = sp_p4;
          end
          default: begin st_nxt = rcraoc_pkg::S_RUN; end
        endcase
      end
      rcraoc_pkg::S_RUN: if (op_valid) begin
        // Fixed 16-bit step, or the slot's pending target.
        ip_we = 1'b1;
        ip_val = pend_r ? tgt_r : ip_r + `RC_INSN_STEP;
        pend_nxt = 1'b0;
        // Register ops retire in the cycle they are taken.
        gwe_a = alu_we;
        sr_we = t_we;
        sr_val = {sr_r[31:1], t_val};
        case (op_code)
          rcraoc_pkg::OP_LOAD, rcraoc_pkg::OP_STORE, rcraoc_pkg::OP_LOAD_LIT: begin
            if (mis_ea) begin
              aerr_nxt = 1'b1;
            end else begin
              mreq_nxt = 1'b1;
              mwe_nxt = is_st;
              msz_nxt = op_size;
              maddr_nxt = mem_ea;
              mwd_nxt = rn_val;
              seq_nxt = is_st ? rcraoc_pkg::Q_STORE : rcraoc_pkg::Q_LOAD;
              st_nxt = rcraoc_pkg::S_REQ;
            end
          end
          rcraoc_pkg::OP_AND_MEM: begin
            mreq_nxt = 1'b1;
            msz_nxt = rcraoc_pkg::SZ_B;
            maddr_nxt = pbp_ea;
            seq_nxt = rcraoc_pkg::Q_RMW_RD;
            st_nxt = rcraoc_pkg::S_REQ;
          end
          // Unconditional branches run their slot first.
          rcraoc_pkg::OP_BRA: pend_nxt = 1'b1;
          rcraoc_pkg::OP_CALL: begin pend_nxt = 1'b1; rl_we = 1'b1; end
          // Ordinary conditional branches jump at once.
          rcraoc_pkg::OP_BT: if (t_now) ip_val = br_tgt;
          rcraoc_pkg::OP_BF: if (!t_now) ip_val = br_tgt;
          rcraoc_pkg::OP_BTS: pend_nxt = t_now;
          rcraoc_pkg::OP_BFS: pend_nxt = !t_now;
          rcraoc_pkg::OP_MUL16, rcraoc_pkg::OP_MAC16, rcraoc_pkg::OP_MUL32,
          rcraoc_pkg::OP_MAC32: st_nxt = rcraoc_pkg::S_MUL;
          // First push holds the status word.
          rcraoc_pkg::OP_TRAP: begin
            if (mis_sp) begin
              aerr_nxt = 1'b1;
            end else begin
              gwe_b = 1'b1;
              gval_b = sp_m4;
              mreq_nxt = 1'b1;
              mwe_nxt = 1'b1;
              maddr_nxt = sp_m4;
              mwd_nxt = sr_r;
              seq_nxt = rcraoc_pkg::Q_EXC_SR;
              st_nxt = rcraoc_pkg::S_REQ;
            end
          end
          rcraoc_pkg::OP_RTE: begin
            if (mis_sp) begin
              aerr_nxt = 1'b1;
            end else begin
              mreq_nxt = 1'b1;
              maddr_nxt = sp_val;
              seq_nxt = rcraoc_pkg::Q_RTE_PC;
              st_nxt = rcraoc_pkg::S_REQ;
            end
          end
          default: begin pend_nxt = 1'b0; end
        endcase
      end
    endcase
  end

  // Mask ones, reserved zero, vector base zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= rcraoc_pkg::S_BOOT;
      seq_r <= rcraoc_pkg::Q_BOOT_PC;
      sr_r <= `RC_SR_RESET;
      vtb_r <= `RC_VTB_RESET;
      ip_r <= 32'h00000000;
      pend_r <= 1'b0;
      fault_r <= 1'b0;
      op_ready_r <= 1'b0;
      addr_err_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      msz_r <= rcraoc_pkg::SZ_L;
      mem_addr_r <= 32'h00000000;
      mem_wdata_r <= 32'h00000000;
      sw_rdata_r <= 32'h00000000;
      mcnt_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      seq_r <= seq_nxt;
      op_ready_r <= (st_nxt == rcraoc_pkg::S_RUN);
      addr_err_r <= aerr_nxt;
      mem_req_r <= mreq_nxt;
      mem_we_r <= mwe_nxt;
      msz_r <= msz_nxt;
      mem_addr_r <= maddr_nxt;
      mem_wdata_r <= mwd_nxt;
      sw_rdata_r <= sw_rd ? sw_sel : 32'h00000000;
      // The count loads only outside a multiply, since a held op code must not reload it.
      mcnt_r <= (st_r == rcraoc_pkg::S_MUL) ? mcnt_r - 3'h1 : mcnt_nxt;
      pend_r <= pend_nxt;
      // A fault in the clearing cycle survives the clear.
      fault_r <= aerr_nxt || (fault_r && !(sw_wx && sw_idx == `RC_IDX_FAULT));
      if (ip_we) ip_r <= ip_val;
      if (sr_we) sr_r <= sr_val;
      if (sw_wx && sw_idx == `RC_IDX_SR) sr_r <= sw_wdata & `RC_SR_MASK;
      if (sw_wx && sw_idx == `RC_IDX_VTB) vtb_r <= sw_wdata;
      if (sw_wx && sw_idx == `RC_IDX_IP) ip_r <= sw_wdata;
    end
  end

  // Data registers carry no reset; software sees whatever was left in them.
  always_ff @(posedge clk_sys) begin
    if (take) begin
      dst_r <= op_rn;
      imm_r <= op_imm;
      ldsz_r <= op_size;
      mres_r <= mres_nxt;
      tgt_r <= br_tgt;
    end
    // Call keeps its return; products land in the halves.
    if (take && rl_we) rlink_r <= ip_r + `RC_BR_BIAS;
    if (st_r == rcraoc_pkg::S_MUL && mcnt_r == 3'h1) begin
      mac_high_half_r <= mres_r[63:32];
      mac_low_half_r <= mres_r[31:0];
    end
    if (gwe_a) gpr_r[gidx_a] <= gval_a;
    if (gwe_b) gpr_r[`RC_SP_IDX] <= gval_b;
    if (sw_wgp) gpr_r[sw_idx[3:0]] <= sw_wdata;
    if (sw_wx && sw_idx == `RC_IDX_PBP) pbp_r <= sw_wdata;
    if (sw_wx && sw_idx == `RC_IDX_MAC_HIGH_HALF) mac_high_half_r <= sw_wdata;
    if (sw_wx && sw_idx == `RC_IDX_MAC_LOW_HALF) mac_low_half_r <= sw_wdata;
    if (sw_wx && sw_idx == `RC_IDX_RLINK) rlink_r <= sw_wdata;
  end

  assign sw_rdata   = sw_rdata_r;
  assign op_ready   = op_ready_r;
  assign fetch_addr = ip_r;
  assign mem_req    = mem_req_r;
  assign mem_we     = mem_we_r;
  assign mem_size   = msz_r;
  assign mem_addr   = mem_addr_r;
  assign mem_wdata  = mem_wdata_r;
  assign addr_err   = addr_err_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence bra_taken_s;
    take && op_code == rcraoc_pkg::OP_BRA && !sw_wr;
  endsequence
  sequence slot_taken_s;
    take && !sw_wr && op_code == rcraoc_pkg::OP_ADD_REG;
  endsequence

  boot_vector_a: assert property ($fell(rst) |=>
    mem_req_r && !mem_we_r && mem_addr_r == `RC_VEC_PC_OFS) else $error("Boot fetch wrong.");
  reset_state_a: assert property ($past(rst) |->
    sr_r == `RC_SR_RESET && vtb_r == `RC_VTB_RESET) else $error("Reset values wrong.");
  align_error_a: assert property (take && is_mem && mis_ea |=>
    addr_err_r && !mem_req_r ##1 !addr_err_r) else $error("Misaligned access passed.");
  stack_word_a: assert property (mem_req_r && (seq_r == rcraoc_pkg::Q_EXC_SR ||
    seq_r == rcraoc_pkg::Q_EXC_PC || seq_r == rcraoc_pkg::Q_RTE_PC)
    |-> msz_r == rcraoc_pkg::SZ_L && mem_addr_r[1:0] == 2'b00) else $error("Stack not aligned.");
  byte_sext_a: assert property (st_r == rcraoc_pkg::S_DAT && seq_r == rcraoc_pkg::Q_LOAD &&
    ldsz_r == rcraoc_pkg::SZ_B && !sw_wr |=> gpr_r[$past(dst_r)] ==
    {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])}) else $error("Byte load not extended.");
  move_sext_a: assert property (take && op_code == rcraoc_pkg::OP_MOV_IMM && !sw_wr
    |=> gpr_r[$past(op_rn)] == {{24{$past(op_imm[7])}}, $past(op_imm)}) else $error("Move imm.");
  and_zext_a: assert property (take && op_code == rcraoc_pkg::OP_AND_IMM && !sw_wr
    |=> gpr_r[0][31:8] == 24'h000000) else $error("And immediate not zero-extended.");
  insn_step_a: assert property (take && !pend_r && op_code == rcraoc_pkg::OP_ADD_REG && !sw_wr
    |=> ip_r == $past(ip_r) + `RC_INSN_STEP && op_ready_r) else $error("Pointer step wrong.");
  delay_slot_a: assert property (bra_taken_s ##1 slot_taken_s
    |=> ip_r == $past(tgt_r) && !pend_r) else $error("Slot did not precede branch.");
  cond_plain_a: assert property (take && op_code == rcraoc_pkg::OP_BT && !t_now && !sw_wr
    |=> ip_r == $past(ip_r) + `RC_INSN_STEP && !pend_r) else $error("False branch taken.");
  mul_long_a: assert property (take && op_code == rcraoc_pkg::OP_MUL32
    |=> !op_ready_r [*3] ##1 op_ready_r) else $error("Long multiply cycle count wrong.");
endmodule : rcraoc_core
`default_nettype wire

/* File: hw/rcraoc_regs.svh */
// Constants of the register and operand core: register indices, status word fields,
// reset values, vector offsets and operation timing.
// Assumes a 32-bit core clocked by clk_sys and a single-cycle memory that answers reads
// in the cycle after the request.
`ifndef RCRAOC_REGS_SVH
`define RCRAOC_REGS_SVH

`define RC_IDX_SR     5'h10
`define RC_IDX_PBP    5'h11
`define RC_IDX_VTB    5'h12
`define RC_IDX_MAC_HIGH_HALF   5'h13
`define RC_IDX_MAC_LOW_HALF   5'h14
`define RC_IDX_RLINK  5'h15
`define RC_IDX_IP     5'h16
`define RC_IDX_FAULT  5'h17

`define RC_SR_T       0
`define RC_SR_MASK    32'h000003f3
`define RC_SR_RESET   32'h000000f0
`define RC_VTB_RESET  32'h00000000

`define RC_VEC_PC_OFS 32'h00000000
`define RC_VEC_SP_OFS 32'h00000004
`define RC_STACK_STEP 32'h00000004
`define RC_INSN_STEP  32'h00000002
`define RC_BR_BIAS    32'h00000004
`define RC_SP_IDX     4'hf

`define RC_MUL16_CYC  2
`define RC_MAC16_CYC  3
`define RC_MUL32_CYC  4

`endif

/* File: hw/rcraoc_pkg.sv */
// Types of the register and operand core: operation codes, access sizes and sequencer states.
// Assumes the decoder in front of the core delivers one decoded operation per accepted cycle.
`default_nettype none
package rcraoc_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_MOV_IMM, OP_ADD_IMM, OP_CMPEQ_IMM, OP_TST_IMM, OP_AND_IMM, OP_OR_IMM,
    OP_XOR_IMM, OP_MOV_REG, OP_ADD_REG, OP_CMPEQ_REG, OP_LOAD, OP_STORE, OP_LOAD_LIT,
    OP_AND_MEM, OP_BRA, OP_CALL, OP_BT, OP_BF, OP_BTS, OP_BFS, OP_MUL16, OP_MAC16,
    OP_MUL32, OP_MAC32, OP_TRAP, OP_RTE
  } rcraoc_op_t;
  typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} rcraoc_size_t;
  typedef enum logic [2:0] {S_BOOT, S_RUN, S_REQ, S_DAT, S_MUL} rcraoc_st_t;
  typedef enum logic [3:0] {
    Q_BOOT_PC, Q_BOOT_SP, Q_LOAD, Q_STORE, Q_RMW_RD, Q_RMW_WR,
    Q_EXC_SR, Q_EXC_PC, Q_EXC_VEC, Q_RTE_PC, Q_RTE_SR
  } rcraoc_seq_t;
endpackage : rcraoc_pkg
`default_nettype wire

/* File: tb/rcraoc_mem.sv */
// Memory model on the far side of the core: reads answered in the next cycle.
// Assumes one-cycle mem_req pulses and no wait states.
`default_nettype none
module rcraoc_mem (
  input  wire logic                     clk_sys,
  input  wire logic                     mem_req,
  input  wire logic                     mem_we,
  input  wire rcraoc_pkg::rcraoc_size_t mem_size,
  input  wire logic [31:0]              mem_addr,
  input  wire logic [31:0]              mem_wdata,
  output logic      [31:0]              mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m [256];
  initial begin
    for (int i = 0; i < 256; i++) m[i] = 8'(i) ^ 8'ha5;
    mem_rdata = 32'h0;
  end
  // Data toggles outside the answer cycle, so a late sample cannot match by luck.
  always @(posedge clk_sys) begin
    int n;
    logic [31:0] r;
    n = 1 << mem_size;
    r = 32'h0;
    for (int k = 0; k < n; k++) begin
      if (mem_req && mem_we) m[8'(mem_addr + k)] <= 8'(mem_wdata >> (8 * (n - 1 - k)));
      r = {r[23:0], m[8'(mem_addr + k)]};
    end
    mem_rdata <= (mem_req && !mem_we) ? r : ~mem_rdata;
  end
endmodule : rcraoc_mem
`default_nettype wire

/* File: tb/tb_risc_cpu_register_and_operand_core.sv */
// Self-checking bench of the register and operand core.
// Assumes the memory model answers every read and the design defaults.
`include "rcraoc_regs.svh"
`default_nettype none
module tb_risc_cpu_register_and_operand_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst, sw_wr, sw_rd, op_valid, op_idx, op_ready, mem_req, mem_we;
  logic        addr_err, e, q;
  logic [7:0]  sw_addr, op_imm, a;
  logic [31:0] sw_wdata, sw_rdata, fetch_addr, mem_addr, mem_wdata, mem_rdata, v, d;
  logic [3:0]  op_rn, op_rm;
  logic [11:0] op_disp;
  rcraoc_pkg::rcraoc_op_t   op_code;
  rcraoc_pkg::rcraoc_size_t op_size, mem_size;
  int          miscompares, checks_done, cyc, n, k;
  rcraoc_pkg::rcraoc_op_t mo [4] = '{rcraoc_pkg::OP_MUL16, rcraoc_pkg::OP_MAC16,
                                     rcraoc_pkg::OP_MUL32, rcraoc_pkg::OP_MAC32};
  int mc [4] = '{`RC_MUL16_CYC - 1, `RC_MAC16_CYC - 1, `RC_MUL32_CYC - 1, `RC_MUL32_CYC - 1};
  rcraoc_core uut (.clk_sys, .rst, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .op_valid,
    .op_code, .op_rn, .op_rm, .op_imm, .op_size, .op_idx, .op_disp, .op_ready, .fetch_addr,
    .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_rdata, .addr_err);
  rcraoc_mem mem (.clk_sys, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_rdata);
  function automatic logic [31:0] ld(input logic [7:0] ad, input int nb);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < nb; i++) r = {r[23:0], 8'(ad + i) ^ 8'ha5};
    return nb == 1 ? {{24{r[7]}}, r[7:0]} : nb == 2 ? {{16{r[15]}}, r[15:0]} : r;
  endfunction : ld
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk_sys);
    sw_wr <= 1'b1;
    sw_addr <= ad;
    sw_wdata <= dt;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_sys);
    sw_rd <= 1'b1;
    sw_addr <= ad;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    @(posedge clk_sys);
    v = sw_rdata;
  endtask : rd
  task automatic do_op(input rcraoc_pkg::rcraoc_op_t c, input logic [7:0] im, input int sz);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= c;
    op_imm <= im;
    op_size <= rcraoc_pkg::rcraoc_size_t'(sz);
    do @(posedge clk_sys); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    @(posedge clk_sys);
    e = addr_err;
    q = mem_req;
    for (n = 0; n < 20 && op_ready !== 1'b1; n++) @(posedge clk_sys);
  endtask : do_op
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rst, sw_wr, sw_rd, op_valid, op_idx, sw_addr, sw_wdata, op_imm, op_disp} = '0;
    {op_rn, op_rm, cyc, miscompares, checks_done} = '0;
    rst = 1'b1;
    op_code = rcraoc_pkg::OP_NOP;
    op_size = rcraoc_pkg::SZ_L;
    void'($urandom(46133));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (n = 0; n < 40 && op_ready !== 1'b1; n++) @(posedge clk_sys);
    rd(8'h40);
    chk(v, 32'h000000f0);
    rd(8'h48);
    chk(v, 32'h00000000);
    rd(8'h58);
    chk(v, ld(8'h00, 4));
    rd(8'h3c);
    chk(v, ld(8'h04, 4));
    $display("reset test done");
    for (int j = 0; j < 16; j++) begin
      d = $urandom;
      wr(8'(j * 4), d);
      rd(8'(j * 4));
      chk(v, d);
    end
    rd(8'h80);
    chk(v, 32'h0);
    $display("register test done");
    op_rn <= 4'h2;
    op_rm <= 4'h1;
    for (int j = 0; j < 8; j++) begin
      a = 8'($urandom);
      d = $urandom;
      do_op(rcraoc_pkg::OP_MOV_IMM, a, 2);
      rd(8'h08);
      chk(v, {{24{a[7]}}, a});
      wr(8'h00, d);
      do_op(rcraoc_pkg::OP_AND_IMM, a, 2);
      rd(8'h00);
      chk(v, d & {24'h0, a});
    end
    $display("immediate test done");
    for (int j = 0; j < 12; j++) begin
      k = 1 << (j % 3);
      a = 8'($urandom) & ~8'(k - 1);
      if (j > 5 && k > 1) a = a | 8'h01;
      wr(8'h04, {24'h0, a});
      do_op(rcraoc_pkg::OP_LOAD, 8'h0, j % 3);
      chk(32'(e), 32'((a % k) != 0));
      chk(32'(q), 32'((a % k) == 0));
      if (a % k == 0) begin
        chk(n, 2);
        rd(8'h08);
        chk(v, ld(a, k));
      end
    end
    wr(8'h58, 32'h00000012);
    do_op(rcraoc_pkg::OP_LOAD_LIT, 8'h02, 2);
    rd(8'h08);
    chk(v, ld(8'h1c, 4));
    $display("load test done");
    // Branch, its slot, a false plain branch and an add, all back to back.
    wr(8'h58, 32'h00000100);
    op_disp <= 12'h010;
    op_valid <= 1'b1;
    op_code <= rcraoc_pkg::OP_BRA;
    @(posedge clk_sys);
    op_code <= rcraoc_pkg::OP_ADD_REG;
    @(posedge clk_sys);
    op_code <= rcraoc_pkg::OP_BT;
    @(posedge clk_sys);
    chk(fetch_addr, 32'h00000124);
    op_code <= rcraoc_pkg::OP_ADD_REG;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    @(posedge clk_sys);
    chk(fetch_addr, 32'h00000128);
    d = $urandom;
    wr(8'h04, 32'h00000040);
    wr(8'h08, d);
    do_op(rcraoc_pkg::OP_STORE, 8'h0, 2);
    chk(n, 2);
    wr(8'h44, 32'h00000030);
    wr(8'h00, 32'h00000010);
    do_op(rcraoc_pkg::OP_AND_MEM, a, 0);
    chk(n, 4);
    do_op(rcraoc_pkg::OP_LOAD, 8'h0, 0);
    rd(8'h08);
    chk(v, {{24{d[31] & a[7]}}, d[31:24] & a});
    $display("branch and memory test done");
    wr(8'h3c, 32'h00000082);
    do_op(rcraoc_pkg::OP_TRAP, 8'h0, 2);
    chk(32'({e, q}), 32'h2);
    rd(8'h5c);
    chk(v, 32'h1);
    wr(8'h3c, 32'h00000080);
    wr(8'h58, 32'h00000200);
    do_op(rcraoc_pkg::OP_TRAP, 8'h01, 2);
    chk(n, 6);
    rd(8'h58);
    chk(v, ld(8'h04, 4));
    do_op(rcraoc_pkg::OP_RTE, 8'h0, 2);
    chk(n, 4);
    rd(8'h58);
    chk(v, 32'h00000202);
    rd(8'h3c);
    chk(v, 32'h00000080);
    rd(8'h40);
    chk(v, 32'h000000f0);
    $display("stack test done");
    foreach (mo[i]) begin
      d = $urandom & 32'h7fff;
      wr(8'h04, d);
      wr(8'h08, d);
      wr(8'h4c, 32'h0);
      wr(8'h50, 32'h0);
      do_op(mo[i], 8'h0, 2);
      chk(n, mc[i]);
      rd(8'h50);
      chk(v, d * d);
      rd(8'h4c);
      chk(v, 32'h0);
    end
    $display("multiply test done");
    print_verdict();
  end
endmodule : tb_risc_cpu_register_and_operand_core
`default_nettype wire
